/* verilog/sac_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

module sac_top
   import sac_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic COMP_IN,
   input wire logic RC_OSC_IN,
   input wire logic SLEEP_IN,
   input wire logic SMALL_PKG_IN,
   output sac_analog_s ANALOG,
   output logic IRQ,
   output logic WAKE_REQ
);
   logic ack_reg;
   logic ack_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [3:0] irq_reg;
   logic [3:0] irq_next;
   logic [15:0] res_reg;
   logic [15:0] res_next;
   sac_state_e st_reg;
   sac_state_e st_next;
   logic [1:0] hold_reg;
   logic [1:0] hold_next;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic rc_last_reg;

   logic comp_s;
   logic rc_s;
   logic sleep_s;
   logic small_s;
   logic rc_tick;
   logic tad_tick;
   logic wr_ok;
   logic wr_ctl;
   logic go_bit;
   logic busy;
   logic start_req;
   logic abort;
   logic sar_start;
   logic sar_step;
   logic sar_done;
   logic load;
   logic [9:0] sar_trial;
   logic [9:0] sar_result;
   sac_clksel_e clk_sel;

   // Asynchronous inputs pass two flops; only the second stage is read.
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         rc_last_reg <= 1'b0;
      end else begin
         sync1_reg <= {SMALL_PKG_IN, SLEEP_IN, RC_OSC_IN};
         sync2_reg <= sync1_reg;
         rc_last_reg <= sync2_reg[0];
      end
   end

   // The comparator is latched on this same clock, so it has no synchroniser.
   // Two flops here would make a divide-by-2 bit period decide on the previous trial code.
   assign comp_s = COMP_IN;
   assign rc_s = sync2_reg[0];
   assign sleep_s = sync2_reg[1];
   assign small_s = sync2_reg[2];
   assign rc_tick = rc_s & ~rc_last_reg;
   assign clk_sel = sac_clksel_e'(ctl_reg[`SAC_CTL_CS_HI:`SAC_CTL_CS_LO]);

   // One wait state: the request is seen, then answered on the next edge.
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
   assign AVS_READDATA = {24'h00_0000, rdata_reg};
   assign wr_ok = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
   assign wr_ctl = wr_ok && AVS_ADDRESS == {`SAC_IDX_CTL, 2'b00};

   assign busy = (st_reg == ST_START) || (st_reg == ST_CONV);
   assign go_bit = busy;
   // Go is honoured only from acquisition with power already on.
   assign start_req = wr_ctl && AVS_WRITEDATA[`SAC_CTL_GO] && ctl_reg[`SAC_CTL_ON] && st_reg == ST_ACQ;
   assign abort = wr_ctl && !AVS_WRITEDATA[`SAC_CTL_GO] && busy;
   assign sar_start = st_reg == ST_START && tad_tick && !abort;
   assign sar_step = st_reg == ST_CONV && tad_tick;
   assign load = sar_done && !abort;

   always_comb begin
      ack_next = (AVS_READ | AVS_WRITE) & ~ack_reg;
      rdata_next = rdata_reg;
      if (AVS_READ && !ack_reg) begin
         case (AVS_ADDRESS)
            {`SAC_IDX_CTL, 2'b00}: rdata_next = {ctl_reg[7:3], go_bit, 1'b0, ctl_reg[0]};
            {`SAC_IDX_CFG, 2'b00}: rdata_next = cfg_reg;
            {`SAC_IDX_IRQ, 2'b00}: rdata_next = {4'h0, irq_reg};
            {`SAC_IDX_RESH, 2'b00}: rdata_next = res_reg[15:8];
            {`SAC_IDX_RESL, 2'b00}: rdata_next = res_reg[7:0];
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_comb begin
      ctl_next = ctl_reg;
      cfg_next = cfg_reg;
      irq_next = irq_reg;
      res_next = res_reg;
      if (wr_ctl) begin
         ctl_next = AVS_WRITEDATA[7:0] & `SAC_CTL_WMASK;
      end
      if (wr_ok && AVS_ADDRESS == {`SAC_IDX_CFG, 2'b00}) begin
         cfg_next = AVS_WRITEDATA[7:0] & `SAC_CFG_WMASK;
      end
      if (wr_ok && AVS_ADDRESS == {`SAC_IDX_IRQ, 2'b00}) begin
         irq_next = AVS_WRITEDATA[3:0];
      end
      if (wr_ok && AVS_ADDRESS == {`SAC_IDX_RESH, 2'b00}) begin
         res_next[15:8] = AVS_WRITEDATA[7:0];
      end
      if (wr_ok && AVS_ADDRESS == {`SAC_IDX_RESL, 2'b00}) begin
         res_next[7:0] = AVS_WRITEDATA[7:0];
      end
      // Completion beats a software clear or write in the same cycle.
      if (load) begin
         irq_next[`SAC_IRQ_FLAG] = 1'b1;
         if (cfg_reg[`SAC_CFG_JUST]) begin
            res_next = {6'h00, sar_result};
         end else begin
            res_next = {sar_result, 6'h00};
         end
      end
   end

   always_comb begin
      st_next = st_reg;
      hold_next = 2'h0;
      case (st_reg)
         ST_OFF: begin
            if (ctl_reg[`SAC_CTL_ON]) begin
               st_next = ST_ACQ;
            end
         end
         ST_ACQ: begin
            // Settling time is left to software before it sets go.
            if (start_req) begin
               st_next = ST_START;
            end
         end
         ST_START: begin
            if (abort) begin
               st_next = ST_HOLD;
            end else if (tad_tick) begin
               st_next = ST_CONV;
            end
         end
         ST_CONV: begin
            if (abort || load) begin
               st_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            hold_next = hold_reg;
            if (tad_tick) begin
               if (hold_reg == `SAC_HOLD_TADS - 2'h1) begin
                  st_next = ST_ACQ;
                  hold_next = 2'h0;
               end else begin
                  hold_next = hold_reg + 2'h1;
               end
            end
         end
         default: st_next = ST_OFF;
      endcase
      if (!ctl_reg[`SAC_CTL_ON]) begin
         st_next = ST_OFF;
         hold_next = 2'h0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_reg <= 1'b0;
         rdata_reg <= 8'h00;
         ctl_reg <= `SAC_CTL_RESET;
         cfg_reg <= `SAC_CFG_RESET;
         irq_reg <= `SAC_IRQ_RESET;
         res_reg <= `SAC_RES_RESET;
         st_reg <= ST_OFF;
         hold_reg <= 2'h0;
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         ctl_reg <= ctl_next;
         cfg_reg <= cfg_next;
         irq_reg <= irq_next;
         res_reg <= res_next;
         st_reg <= st_next;
         hold_reg <= hold_next;
      end
   end

   sac_clkdiv u_clkdiv (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .run(st_reg != ST_OFF),
      .sleep(sleep_s),
      .sel(clk_sel),
      .rc_tick(rc_tick),
      .tad_tick(tad_tick)
   );

   sac_sar u_sar (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .start(sar_start),
      .step(sar_step),
      .comp(comp_s),
      .trial(sar_trial),
      .result(sar_result),
      .done(sar_done)
   );

   always_comb begin
      ANALOG.channel = ctl_reg[`SAC_CTL_CH_HI:`SAC_CTL_CH_LO];
      // Channels above four have no pin on the small package.
      ANALOG.chan_valid = !(small_s && ANALOG.channel > `SAC_SMALL_MAX_CH);
      ANALOG.sample = st_reg == ST_ACQ;
      ANALOG.trial = sar_trial;
      ANALOG.ref_hi_pin = cfg_reg[`SAC_CFG_REFHI];
      ANALOG.ref_lo_pin = cfg_reg[`SAC_CFG_REFLO];
   end

   assign IRQ = irq_reg[`SAC_IRQ_FLAG] & irq_reg[`SAC_IRQ_CONV_EN]
      & irq_reg[`SAC_IRQ_PERI_EN] & irq_reg[`SAC_IRQ_GLOB_EN];
   // Wake ignores the peripheral and global enables.
   assign WAKE_REQ = irq_reg[`SAC_IRQ_FLAG] & irq_reg[`SAC_IRQ_CONV_EN] & sleep_s;

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   chk_go_while_busy: assert property (
      AVS_READ && !ack_reg && AVS_ADDRESS == {`SAC_IDX_CTL, 2'b00} |=> rdata_reg[`SAC_CTL_GO] == $past(busy))
      else $error("go not shown while converting");
   chk_done_sets_flag: assert property (load && !wr_ctl |=> irq_reg[`SAC_IRQ_FLAG] && st_reg == ST_HOLD)
      else $error("completion did not set flag");
   chk_irq_needs_global: assert property (!irq_reg[`SAC_IRQ_GLOB_EN] || !irq_reg[`SAC_IRQ_PERI_EN] |-> !IRQ)
      else $error("interrupt raised without enables");
   chk_abort_keeps_result: assert property (abort && AVS_WRITEDATA[`SAC_CTL_ON] |=> $stable(res_reg) && st_reg == ST_HOLD)
      else $error("abort touched result");
   chk_result_cause: assert property ($changed(res_reg) |-> $past(load) || $past(wr_ok))
      else $error("result changed without cause");
   chk_right_justify: assert property (load && cfg_reg[`SAC_CFG_JUST] |=> res_reg[15:10] == 6'h00)
      else $error("unused result bits not zero");
   chk_hold_two_tads: assert property (
      st_reg == ST_HOLD && st_next == ST_ACQ |-> hold_reg == `SAC_HOLD_TADS - 2'h1 && tad_tick)
      else $error("acquisition restarted early");
   chk_power_off: assert property (!ctl_reg[`SAC_CTL_ON] |=> st_reg == ST_OFF)
      else $error("converter active while off");
   chk_bit1_zero: assert property (ctl_reg[1] == 1'b0 && (ctl_reg[`SAC_CTL_GO] == 1'b0))
      else $error("unused control bit set");
   chk_first_segment: assert property (
      $rose(st_reg == ST_START) && clk_sel != CS_RC && !sleep_s |-> ##[1:32] st_reg != ST_START)
      else $error("first segment longer than a bit period");

endmodule : sac_top
`default_nettype wire

/* verilog/sac_params.svh */
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SAC_IDX_RESL 6'h1D
`define SAC_IDX_RESH 6'h1E
`define SAC_IDX_CTL 6'h1F
`define SAC_IDX_CFG 6'h20
`define SAC_IDX_IRQ 6'h21

// Control register fields.
`define SAC_CTL_CS_HI 7
`define SAC_CTL_CS_LO 6
`define SAC_CTL_CH_HI 5
`define SAC_CTL_CH_LO 3
`define SAC_CTL_GO 2
`define SAC_CTL_ON 0
`define SAC_CTL_WMASK 8'hF9
`define SAC_CTL_RESET 8'h00

// Configuration register fields.
`define SAC_CFG_REFHI 0
`define SAC_CFG_REFLO 1
`define SAC_CFG_JUST 7
`define SAC_CFG_WMASK 8'h83
`define SAC_CFG_RESET 8'h00

// Interrupt register fields.
`define SAC_IRQ_FLAG 0
`define SAC_IRQ_CONV_EN 1
`define SAC_IRQ_PERI_EN 2
`define SAC_IRQ_GLOB_EN 3
`define SAC_IRQ_RESET 4'h0

`define SAC_RES_RESET 16'h0000

// Bit period terminal counts at the core clock (one less than the divide ratio).
`define SAC_TC_DIV2 5'h01
`define SAC_TC_DIV8 5'h07
`define SAC_TC_DIV32 5'h1F

`define SAC_RES_BITS 10
`define SAC_TRIAL_MSB 10'h200
`define SAC_HOLD_TADS 2'h2
`define SAC_SMALL_MAX_CH 3'h4

`endif

/* verilog/sac_pkg.sv */
package sac_pkg;

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_ACQ = 5'h02,
      ST_START = 5'h04,
      ST_CONV = 5'h08,
      ST_HOLD = 5'h10
   } sac_state_e;

   typedef enum logic [1:0] {
      CS_DIV2 = 2'h0,
      CS_DIV8 = 2'h1,
      CS_DIV32 = 2'h2,
      CS_RC = 2'h3
   } sac_clksel_e;

   typedef struct packed {
      logic [2:0] channel;
      logic chan_valid;
      logic sample;
      logic [9:0] trial;
      logic ref_hi_pin;
      logic ref_lo_pin;
   } sac_analog_s;

endpackage : sac_pkg

/* verilog/sac_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

module sac_clkdiv
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic sleep,
   input wire sac_clksel_e sel,
   input wire logic rc_tick,
   output logic tad_tick
);
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [4:0] term;

   always_comb begin
      case (sel)
         CS_DIV2: term = `SAC_TC_DIV2;
         CS_DIV8: term = `SAC_TC_DIV8;
         default: term = `SAC_TC_DIV32;
      endcase
      // The system oscillator stops in sleep, so only the RC source keeps ticking.
      if (sel == CS_RC) begin
         tad_tick = run & rc_tick;
      end else begin
         tad_tick = run & ~sleep & (cnt_reg == term);
      end
      if (!run || sel == CS_RC || sleep || cnt_reg == term) begin
         cnt_next = 5'h0;
      end else begin
         cnt_next = cnt_reg + 5'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 5'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_sleep_stops_fosc: assert property (sleep && sel != CS_RC |-> !tad_tick)
      else $error("bit period tick from stopped oscillator");
   chk_div32_period: assert property (
      $rose(tad_tick) && sel == CS_DIV32 ##1 (sel == CS_DIV32 && run && !sleep) [*8] |-> !tad_tick)
      else $error("divide by 32 tick came too soon");

endmodule : sac_clkdiv
`default_nettype wire

/* verilog/sac_sar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

module sac_sar
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic step,
   input wire logic comp,
   output logic [9:0] trial,
   output logic [9:0] result,
   output logic done
);
   logic [9:0] trial_reg;
   logic [9:0] trial_next;
   logic [9:0] mask_reg;
   logic [9:0] mask_next;
   logic [9:0] decided;

   // Comparator high means the held input is at or above the trial code.
   always_comb begin
      decided = comp ? trial_reg : (trial_reg & ~mask_reg);
      trial_next = trial_reg;
      mask_next = mask_reg;
      if (start) begin
         trial_next = `SAC_TRIAL_MSB;
         mask_next = `SAC_TRIAL_MSB;
      end else if (step && mask_reg != 10'h000) begin
         trial_next = decided | (mask_reg >> 1);
         mask_next = mask_reg >> 1;
      end
   end

   assign trial = trial_reg;
   assign result = decided;
   assign done = step & mask_reg[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trial_reg <= 10'h000;
         mask_reg <= 10'h000;
      end else begin
         trial_reg <= trial_next;
         mask_reg <= mask_next;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_sar_msb_first: assert property (start |=> trial_reg == `SAC_TRIAL_MSB && mask_reg == `SAC_TRIAL_MSB)
      else $error("approximation did not start at the top bit");
   chk_sar_bit_keep: assert property (step && !start && mask_reg[9] && comp |=> trial_reg[9])
      else $error("accepted bit was dropped");

endmodule : sac_sar
`default_nettype wire

/* tb/sac_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire sac_analog_s analog,
   input wire logic [7:0][9:0] level,
   input wire logic [3:0] rc_half,
   output logic comp,
   output logic rc_osc
);
   logic [9:0] held_reg;
   logic [3:0] rc_cnt_reg;
   // The capacitor keeps its charge once sampling stops, so a slow or aborted run sees one level.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_reg <= 10'h000;
         rc_cnt_reg <= 4'h0;
         rc_osc <= 1'b0;
      end else begin
         if (analog.sample) begin
            held_reg <= level[analog.channel];
         end
         rc_cnt_reg <= (rc_cnt_reg >= rc_half - 4'h1) ? 4'h0 : rc_cnt_reg + 4'h1;
         if (rc_cnt_reg >= rc_half - 4'h1) begin
            rc_osc <= ~rc_osc;
         end
      end
   end
   assign comp = (held_reg >= analog.trial);
endmodule : sac_analog_model
`default_nettype wire

/* tb/sar_adc_conversion_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sar_adc_conversion_control_test;
   import sac_pkg::*;
   localparam logic [7:0] A_RESL = {`SAC_IDX_RESL, 2'b00};
   localparam logic [7:0] A_RESH = {`SAC_IDX_RESH, 2'b00};
   localparam logic [7:0] A_CTL = {`SAC_IDX_CTL, 2'b00};
   localparam logic [7:0] A_CFG = {`SAC_IDX_CFG, 2'b00};
   localparam logic [7:0] A_IRQ = {`SAC_IDX_IRQ, 2'b00};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic comp_in;
   logic rc_osc_in;
   logic sleep_in = 1'b0;
   logic small_pkg_in = 1'b0;
   sac_analog_s analog;
   logic irq;
   logic wake_req;
   logic [7:0][9:0] level = '0;
   logic [3:0] rc_half = 4'h3;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;

   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   sac_top u_sac_top (.CORE_CLK(core_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .COMP_IN(comp_in), .RC_OSC_IN(rc_osc_in),
      .SLEEP_IN(sleep_in), .SMALL_PKG_IN(small_pkg_in), .ANALOG(analog), .IRQ(irq),
      .WAKE_REQ(wake_req));
   sac_analog_model u_sac_analog_model (.clk(core_clk), .rst_n(resetn), .analog(analog),
      .level(level), .rc_half(rc_half), .comp(comp_in), .rc_osc(rc_osc_in));

   task automatic complete_run();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   // The request stands until an edge that samples waitrequest low; that edge takes the write and the read data.
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] be,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         @(posedge core_clk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      `CHK(n, 1)
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, 4'hF, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(a, 1'b0, 8'h00, 4'hF, q);
   endtask : rd

   task automatic hold_gap(input int lo, input int hi);
      int n;
      n = 0;
      while (analog.sample !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1)
   endtask : hold_gap

   function automatic logic [15:0] justify(input logic [9:0] v, input logic jr);
      return jr ? {6'h00, v} : {v, 6'h00};
   endfunction : justify

   task automatic convert(input logic [1:0] cs, input logic [2:0] ch, input logic jr, input logic [7:0] ie);
      logic [7:0] ctl;
      logic [31:0] q;
      logic [15:0] res;
      int t0;
      int n;
      int conv_bit_period;
      ctl = {cs, ch, 3'b001};
      conv_bit_period = 2 << (2 * cs);
      wr(A_CFG, {jr, 7'h00});
      wr(A_IRQ, ie);
      wr(A_CTL, ctl);
      res = justify(level[ch], jr);
      repeat (80) @(posedge core_clk);
      wr(A_CTL, ctl | 8'h04);
      t0 = cyc;
      rd(A_CTL, q);
      `CHK(q, {24'h00_0000, ctl | 8'h04})
      `CHK(analog.sample, 1'b0)
      n = 0;
      while (q[2] !== 1'b0 && n < 3000) begin
         rd(A_CTL, q);
         n++;
      end
      `CHK(q, {24'h00_0000, ctl})
      if (cs != 2'h3) begin
         `CHK((cyc - t0) >= 10 * conv_bit_period && (cyc - t0) <= 11 * conv_bit_period + 8, 1'b1)
      end
      rd(A_RESL, q);
      `CHK(q, {24'h00_0000, res[7:0]})
      rd(A_RESH, q);
      `CHK(q, {24'h00_0000, res[15:8]})
      rd(A_IRQ, q);
      `CHK(q[0], 1'b1)
   endtask : convert

   initial begin
      logic [31:0] q;
      logic [7:0] adr [7];
      logic [7:0] b0;
      logic [7:0] b1;
      logic [2:0] ch;
      q = $urandom(32'h0000_c33d);
      adr = '{A_CTL, A_CFG, A_IRQ, A_RESL, A_RESH, 8'h00, 8'hFC};
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      foreach (adr[i]) begin
         rd(adr[i], q);
         `CHK(q, 32'h0000_0000)
      end
      wr(A_CTL, 8'hFF);
      rd(A_CTL, q);
      `CHK(q, 32'h0000_00F9)
      wr(A_CTL, 8'h00);
      wr(A_CTL, 8'h04);
      rd(A_CTL, q);
      `CHK(q, 32'h0000_0000)
      wr(8'h00, 8'hFF);
      bus(A_CTL, 1'b1, 8'h08, 4'hE, q);
      rd(A_CTL, q);
      `CHK(q, 32'h0000_0000)
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         small_pkg_in <= i[3];
         wr(A_CTL, {2'b00, i[2:0], 3'b000});
         wr(A_CFG, {6'h00, i[1:0]});
         @(negedge core_clk);
         `CHK(analog.channel, i[2:0])
         `CHK(analog.chan_valid, !(i[3] && i[2:0] > 3'h4))
         `CHK({analog.ref_lo_pin, analog.ref_hi_pin}, i[1:0])
      end
      for (int i = 0; i < 4; i++) begin
         b0 = 8'($urandom);
         b1 = 8'($urandom);
         wr(A_RESL, b0);
         wr(A_RESH, b1);
         rd(A_RESL, q);
         `CHK(q[7:0], b0)
         rd(A_RESH, q);
         `CHK(q[7:0], b1)
      end
      for (int e = 0; e < 8; e++) begin
         wr(A_IRQ, {4'h0, e[2:0], 1'b1});
         @(negedge core_clk);
         `CHK(irq, &e[2:0])
         wr(A_IRQ, {4'h0, e[2:0], 1'b0});
         @(negedge core_clk);
         `CHK(irq, 1'b0)
      end
      foreach (level[i]) level[i] <= 10'($urandom);
      level[0] <= 10'h000;
      level[7] <= 10'h3FF;
      convert(2'h0, 3'h0, 1'b1, 8'h00);
      convert(2'h1, 3'h7, 1'b0, 8'h00);
      convert(2'h2, 3'h7, 1'b1, 8'h00);
      hold_gap(28, 70);
      convert(2'h3, 3'h5, 1'b0, 8'h00);
      for (int i = 0; i < 8; i++) begin
         ch = 3'($urandom);
         level[ch] <= 10'($urandom);
         if (i == 4) rc_half <= 4'h9;
         convert(2'($urandom), ch, 1'($urandom), 8'h00);
      end
      wr(A_IRQ, 8'h00);
      wr(A_RESL, 8'hA5);
      wr(A_RESH, 8'h5A);
      wr(A_CTL, 8'h91);
      repeat (80) @(posedge core_clk);
      wr(A_CTL, 8'h95);
      repeat (100) @(posedge core_clk);
      wr(A_CTL, 8'h91);
      hold_gap(28, 70);
      rd(A_RESL, q);
      `CHK(q[7:0], 8'hA5)
      rd(A_RESH, q);
      `CHK(q[7:0], 8'h5A)
      rd(A_IRQ, q);
      `CHK(q[0], 1'b0)
      convert(2'h2, 3'h2, 1'b0, 8'h00);
      @(posedge core_clk);
      rc_half <= 4'h9;
      sleep_in <= 1'b1;
      convert(2'h3, 3'h2, 1'b1, 8'h02);
      @(negedge core_clk);
      `CHK(wake_req, 1'b1)
      `CHK(irq, 1'b0)
      hold_gap(20, 30);
      wr(A_CTL, 8'h11);
      repeat (80) @(posedge core_clk);
      wr(A_CTL, 8'h15);
      repeat (200) @(posedge core_clk);
      rd(A_CTL, q);
      `CHK(q[2], 1'b1)
      wr(A_CTL, 8'h11);
      sleep_in <= 1'b0;
      repeat (10) @(posedge core_clk);
      wr(A_CTL, 8'h05);
      repeat (5) @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      rd(A_CTL, q);
      `CHK(q, 32'h0000_0000)
      rd(A_RESL, q);
      `CHK(q, 32'h0000_0000)
      complete_run();
   end

   initial begin
      // The slowest scenarios need well under ten thousand cycles; twenty thousand leaves margin.
      #400_000;
      err_count++;
      complete_run();
   end
endmodule : sar_adc_conversion_control_test
`default_nettype wire
